// *** hdl/hps_pkg.sv ***
package hps_pkg;
   localparam int HPS_DATA_W   = 8;
   localparam int HPS_WORD_W   = 16;
   localparam int HPS_GPIO_W   = 10;
   localparam int HPS_GPIO_LO  = 36;
   localparam int HPS_GPIO_A   = 44;
   localparam int HPS_GPIO_B   = 45;
   localparam int HPS_GPIO_DHI = 43;
   // GPIO bit positions within the 10-bit local vector
   localparam int HPS_GIDX_A   = HPS_GPIO_A - HPS_GPIO_LO;
   localparam int HPS_GIDX_B   = HPS_GPIO_B - HPS_GPIO_LO;
   localparam int HPS_GIDX_DHI = HPS_GPIO_DHI - HPS_GPIO_LO;
   localparam logic       HPS_STRAP_RST = 1'b0;
   localparam logic [7:0] HPS_BYTE_RST  = 8'h00;
   localparam logic [15:0] HPS_WORD_RST = 16'h0000;
   localparam logic [9:0] HPS_GPIO_RST  = 10'h000;
   localparam logic [1:0] HPS_SEL_CTRL  = 2'h0;
   localparam logic [1:0] HPS_SEL_DINC  = 2'h1;
   localparam logic [1:0] HPS_SEL_ADDR  = 2'h2;
   localparam logic [1:0] HPS_SEL_DATA  = 2'h3;

   typedef enum logic [2:0] {
      HPS_RESET = 3'h1,
      HPS_GPIO  = 3'h2,
      HPS_HOST  = 3'h4
   } hps_mode_t;
endpackage

// *** hdl/hps_strap_latch.sv ***
`timescale 1ns/1ps
module hps_strap_latch
   import hps_pkg::*;
(
   input  wire logic      ref_clk,
   input  wire logic      rst_n,
   input  wire logic      portFunctionStrap,
   output hps_mode_t      mode
);
   hps_mode_t modeQ, modeD;

   // Strap is caught by the first clock after release, never by reset
   always_comb begin
      modeD = modeQ;
      case (modeQ)
         HPS_RESET: modeD = portFunctionStrap ? HPS_HOST : HPS_GPIO; // R8
         HPS_GPIO:  modeD = HPS_GPIO;
         HPS_HOST:  modeD = HPS_HOST;
         default:   modeD = HPS_RESET;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         modeQ <= HPS_RESET;
      end else begin
         modeQ <= modeD;
      end
   end

   assign mode = modeQ;
endmodule // hps_strap_latch

// *** hdl/hps_byte_pair.sv ***
`timescale 1ns/1ps
module hps_byte_pair
   import hps_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire logic                  byteStb,
   input  wire logic                  byteHalfIdentifier,
   input  wire logic [HPS_DATA_W-1:0] byteIn,
   output logic [HPS_WORD_W-1:0]      wordOut,
   output logic                       wordValid
);
   logic [HPS_DATA_W-1:0] firstQ, firstD;
   logic [HPS_WORD_W-1:0] wordQ, wordD;
   logic                  haveQ, haveD, validQ, validD;

   always_comb begin
      firstD = firstQ;
      haveD  = haveQ;
      wordD  = wordQ;
      validD = 1'b0;
      if (byteStb) begin
         if (!byteHalfIdentifier) begin // R18
            firstD = byteIn;
            haveD  = 1'b1;
         end else if (haveQ) begin // R6
            wordD  = {byteIn, firstQ};
            validD = 1'b1;
            haveD  = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         firstQ <= HPS_BYTE_RST;
         haveQ  <= 1'b0;
         wordQ  <= HPS_WORD_RST;
         validQ <= 1'b0;
      end else begin
         firstQ <= firstD;
         haveQ  <= haveD;
         wordQ  <= wordD;
         validQ <= validD;
      end
   end

   assign wordOut   = wordQ;
   assign wordValid = validQ;
endmodule // hps_byte_pair

// *** hdl/hps_pin_mux.sv ***
`timescale 1ns/1ps
// How it works
// R1: Strap high routes data pins to host bus; low to GPIO 43:36.
// R2: GPIO 43:36 are inputs after reset.
// R3: Host data bus is input, drivers off, after reset.
// R4: Strap high during reset selects multiplexed host mode.
// R5: Address and data share the one 8-bit bus.
// R6: Each host cycle is two 8-bit transfers forming 16 bits.
// R7: Control pin A is address strobe if strap high, else GPIO 44.
// R8: Pin functions latched at reset release, fixed until next reset.
// R9: GPIO 44 and 45 are inputs after reset.
// R10: Address strobe is an input.
// R11: Address strobe pulse captures bus address into address register.
// R12: Address strobe only works in multiplexed mode.
// R13: Control pin B is byte identifier if strap high, else GPIO 45.
// R14: Byte identifier is an input.
// R15: Host marks first or second byte with the byte identifier.
// R16: Two select lines pick control, data-inc, address, or data.
// R17: Enable low disables host port; its outputs are high impedance.
// R18: Byte identifier low is first byte, high is second.
module hps_pin_mux
   import hps_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire logic                  portFunctionStrap,
   input  wire logic                  portEnableInput,
   input  wire logic [HPS_DATA_W-1:0] hostDataPinsIn,
   output logic [HPS_DATA_W-1:0]      hostDataPinsOut,
   output logic [HPS_DATA_W-1:0]      hostDataPinsOe,
   input  wire logic                  hostControlPinAIn,
   output logic                       hostControlPinAOut,
   output logic                       hostControlPinAOe,
   input  wire logic                  hostControlPinBIn,
   output logic                       hostControlPinBOut,
   output logic                       hostControlPinBOe,
   input  wire logic                  registerSelectLine0,
   input  wire logic                  registerSelectLine1,
   input  wire logic                  hostDataStb,
   // General-purpose side, bits 45:36 as a 10-bit vector
   input  wire logic [HPS_GPIO_W-1:0] gpioOutVal,
   input  wire logic [HPS_GPIO_W-1:0] gpioDirOut,
   output logic [HPS_GPIO_W-1:0]      gpioInVal,
   // Host-port core side
   input  wire logic [HPS_DATA_W-1:0] hostReadByte,
   input  wire logic                  hostReadDrive,
   output logic                       hostModeActive,
   output logic                       gpioModeActive,
   output logic [HPS_WORD_W-1:0]      hostAddressRegister,
   output logic                       addrLoadPulse,
   output logic [HPS_WORD_W-1:0]      hostWord,
   output logic                       hostWordValid,
   output logic [1:0]                 hostWordSel,
   output logic [HPS_DATA_W-1:0]      hostByte,
   output logic                       hostByteStb,
   output logic                       hostByteHalf
);
   hps_mode_t mode;

   hps_strap_latch u_strap (
      .ref_clk           (ref_clk),
      .rst_n             (rst_n),
      .portFunctionStrap (portFunctionStrap),
      .mode              (mode)
   ); // R8

   logic hostOn;
   logic isHost;
   logic isGpio;
   assign isHost = (mode == HPS_HOST); // R4
   assign isGpio = (mode == HPS_GPIO);
   assign hostOn = isHost && portEnableInput; // R17

   // Select decode; strobe and identifier are ignored outside host mode
   function automatic logic [1:0] sel_code(input logic s1, input logic s0);
      sel_code = {s1, s0};
   endfunction

   // ---- Input sampling registers ----
   logic [HPS_DATA_W-1:0] byteQ, byteD;
   logic                  stbQ, stbD;
   logic                  halfQ, halfD;
   logic [1:0]            selQ, selD;
   logic                  strobeQ, strobeD;
   logic [HPS_GPIO_W-1:0] gpioInQ, gpioInD;

   always_comb begin
      byteD   = hostDataPinsIn; // R5
      stbD    = hostOn && hostDataStb;
      halfD   = hostOn && hostControlPinBIn; // R13 R14 R15
      selD    = sel_code(registerSelectLine1, registerSelectLine0); // R16
      strobeD = hostOn && hostControlPinAIn; // R7 R10 R12
      gpioInD = isGpio ? {hostControlPinBIn, hostControlPinAIn,
                          hostDataPinsIn} : HPS_GPIO_RST; // R1 R7 R13
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         byteQ   <= HPS_BYTE_RST;
         stbQ    <= 1'b0;
         halfQ   <= 1'b0;
         selQ    <= HPS_SEL_CTRL;
         strobeQ <= 1'b0;
         gpioInQ <= HPS_GPIO_RST;
      end else begin
         byteQ   <= byteD;
         stbQ    <= stbD;
         halfQ   <= halfD;
         selQ    <= selD;
         strobeQ <= strobeD;
         gpioInQ <= gpioInD;
      end
   end

   // ---- Address strobe edge and address register ----
   logic                  strobeDlyQ, strobeDlyD;
   logic [HPS_WORD_W-1:0] addrQ, addrD;
   logic                  loadQ, loadD;
   logic [HPS_DATA_W-1:0] addrLowQ, addrLowD;
   logic                  strobeFall;
   assign strobeFall = strobeDlyQ && !strobeQ;

   // Address strobe: rising edge latches the byte, paired by identifier
   always_comb begin
      strobeDlyD = strobeQ;
      addrD      = addrQ;
      addrLowD   = addrLowQ;
      loadD      = 1'b0;
      if (strobeQ && !strobeDlyQ && isHost) begin // R11 R12
         if (!halfQ) begin // R18
            addrLowD = byteQ;
         end else begin
            addrD = {byteQ, addrLowQ}; // R6
            loadD = 1'b1;
         end
      end else if (stbQ && selQ == HPS_SEL_ADDR) begin
         if (!halfQ) begin
            addrLowD = byteQ;
         end else begin
            addrD = {byteQ, addrLowQ};
            loadD = 1'b1;
         end
      end
      if (strobeFall) begin
         strobeDlyD = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         strobeDlyQ <= 1'b0;
         addrQ      <= HPS_WORD_RST;
         addrLowQ   <= HPS_BYTE_RST;
         loadQ      <= 1'b0;
      end else begin
         strobeDlyQ <= strobeDlyD;
         addrQ      <= addrD;
         addrLowQ   <= addrLowD;
         loadQ      <= loadD;
      end
   end

   // ---- Two-byte word assembly for data strobes ----
   hps_byte_pair u_pair (
      .ref_clk            (ref_clk),
      .rst_n              (rst_n),
      .byteStb            (stbQ),
      .byteHalfIdentifier (halfQ),
      .byteIn             (byteQ),
      .wordOut            (hostWord),
      .wordValid          (hostWordValid)
   ); // R6 R15

   // ---- Output drive ----
   logic [HPS_DATA_W-1:0] outByteQ, outByteD;
   logic [HPS_DATA_W-1:0] oeByteQ, oeByteD;
   logic                  oeAQ, oeAD, oeBQ, oeBD;
   logic                  outAQ, outAD, outBQ, outBD;

   // Drivers off through reset and until the strap state is known
   always_comb begin
      outByteD = HPS_BYTE_RST;
      oeByteD  = HPS_BYTE_RST; // R2 R3
      outAD    = 1'b0;
      outBD    = 1'b0;
      oeAD     = 1'b0; // R9 R10
      oeBD     = 1'b0; // R9 R14
      if (isGpio) begin // R1
         outByteD = gpioOutVal[HPS_GIDX_DHI:0];
         oeByteD  = gpioDirOut[HPS_GIDX_DHI:0]; // R2
         outAD    = gpioOutVal[HPS_GIDX_A];
         oeAD     = gpioDirOut[HPS_GIDX_A]; // R7 R9
         outBD    = gpioOutVal[HPS_GIDX_B];
         oeBD     = gpioDirOut[HPS_GIDX_B]; // R13 R9
      end else if (hostOn && hostReadDrive) begin // R17
         outByteD = hostReadByte;
         oeByteD  = {HPS_DATA_W{1'b1}}; // R3
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         outByteQ <= HPS_BYTE_RST;
         oeByteQ  <= HPS_BYTE_RST;
         outAQ    <= 1'b0;
         outBQ    <= 1'b0;
         oeAQ     <= 1'b0;
         oeBQ     <= 1'b0;
      end else begin
         outByteQ <= outByteD;
         oeByteQ  <= oeByteD;
         outAQ    <= outAD;
         outBQ    <= outBD;
         oeAQ     <= oeAD;
         oeBQ     <= oeBD;
      end
   end

   assign hostDataPinsOut     = outByteQ;
   assign hostDataPinsOe      = oeByteQ;
   assign hostControlPinAOut  = outAQ;
   assign hostControlPinAOe   = oeAQ;
   assign hostControlPinBOut  = outBQ;
   assign hostControlPinBOe   = oeBQ;
   assign gpioInVal           = gpioInQ;
   assign hostModeActive      = isHost;
   assign gpioModeActive      = isGpio;
   assign hostAddressRegister = addrQ;
   assign addrLoadPulse       = loadQ;
   assign hostWordSel         = selQ;
   assign hostByte            = byteQ;
   assign hostByteStb         = stbQ;
   assign hostByteHalf        = halfQ;
endmodule // hps_pin_mux

// *** testbench/hps_pin_mux_asserts.sv ***
`timescale 1ns/1ps
module hps_pin_mux_asserts
   import hps_pkg::*;
(
   input wire logic                  ref_clk,
   input wire logic                  rst_n,
   input wire logic                  portEnableInput,
   input wire logic                  hostControlPinAIn,
   input wire logic                  hostControlPinBIn,
   input wire logic [HPS_GPIO_W-1:0] gpioDirOut,
   input wire logic [HPS_DATA_W-1:0] hostDataPinsOe,
   input wire logic                  hostControlPinAOe,
   input wire logic                  hostControlPinBOe,
   input wire logic                  hostModeActive,
   input wire logic                  gpioModeActive,
   input wire logic                  addrLoadPulse,
   input wire logic [HPS_WORD_W-1:0] hostAddressRegister,
   input wire logic                  hostWordValid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_hostOn;
      hostModeActive && portEnableInput;
   endsequence
   sequence s_highStrobe;
      s_hostOn ##0 ($rose(hostControlPinAIn) && hostControlPinBIn);
   endsequence
   a_addr_load: assert property (
      s_highStrobe |-> ##[1:4] addrLoadPulse)
      else $error("address load missing");
   a_addr_hold: assert property (
      !addrLoadPulse |-> $stable(hostAddressRegister))
      else $error("address changed without load");
   a_pulse_single: assert property (addrLoadPulse |=> !addrLoadPulse)
      else $error("address pulse too long");
   a_mode_excl: assert property (
      !(hostModeActive && gpioModeActive))
      else $error("both modes active");
   a_mode_fixed: assert property ((hostModeActive || gpioModeActive)
      |=> $stable({hostModeActive, gpioModeActive}))
      else $error("mode changed after reset");
   a_gpio_dir: assert property (gpioModeActive && $past(gpioModeActive)
      |=> {hostControlPinBOe, hostControlPinAOe, hostDataPinsOe}
          == $past(gpioDirOut))
      else $error("gpio enable mismatch");
   a_host_ctl_in: assert property (hostModeActive && $past(hostModeActive)
      |-> !hostControlPinAOe && !hostControlPinBOe)
      else $error("control pin driven in host mode");
   a_host_off: assert property (hostModeActive && !portEnableInput
      |=> hostDataPinsOe == 8'h00)
      else $error("disabled port drives bus");
   a_gpio_quiet: assert property (gpioModeActive
      |-> !addrLoadPulse && !hostWordValid)
      else $error("host activity in gpio mode");
   a_word_single: assert property (hostWordValid |=> !hostWordValid)
      else $error("word valid too long");
endmodule // hps_pin_mux_asserts
bind hps_pin_mux hps_pin_mux_asserts u_chk (.*);

// *** testbench/hps_host_model.sv ***
`timescale 1ns/1ps
module hps_host_model
   import hps_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  startAddr,
   input  wire logic                  startData,
   input  wire logic [HPS_WORD_W-1:0] word,
   output logic                       mA,
   output logic                       mB,
   output logic                       hostDataStb,
   output logic [HPS_DATA_W-1:0]      mData
);
   logic [2:0] step_q = 3'h0;
   logic [2:0] step_d;
   always_comb begin
      step_d = step_q + 3'h1;
      if (step_q == 3'h0)
         step_d = startAddr ? 3'h1 : (startData ? 3'h6 : 3'h0);
      else if (step_q == 3'h5 || step_q == 3'h7)
         step_d = 3'h0;
   end
   always_ff @(posedge ref_clk) step_q <= step_d;
   // Strobe twice, low gap between, identifier marks byte order
   assign mA = step_q inside {3'h1, 3'h2, 3'h4, 3'h5};
   assign mB = step_q inside {3'h4, 3'h5, 3'h7};
   assign hostDataStb = step_q inside {3'h6, 3'h7};
   // Released bus shows the inverse, never a stale byte
   assign mData = step_q == 3'h0 ? ~word[15:8]
                : (mB ? word[15:8] : word[7:0]);
endmodule // hps_host_model

// *** testbench/host_port_pin_function_strap_test.sv ***
`timescale 1ns/1ps
module host_port_pin_function_strap_test
   import hps_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        portFunctionStrap = 1'b1;
   logic        portEnableInput = 1'b1;
   logic        registerSelectLine0 = 1'b0;
   logic        registerSelectLine1 = 1'b0;
   logic        hostReadDrive = 1'b0;
   logic        startAddr = 1'b0;
   logic        startData = 1'b0;
   logic [7:0]  hostReadByte = 8'h00;
   logic [9:0]  gpioOutVal = 10'h000;
   logic [9:0]  gpioDirOut = 10'h000;
   logic [15:0] word = 16'h0000;
   logic [7:0]  hostDataPinsIn, hostDataPinsOut, hostDataPinsOe, hostByte;
   logic [7:0]  mData;
   logic        hostControlPinAIn, hostControlPinAOut, hostControlPinAOe;
   logic        hostControlPinBIn, hostControlPinBOut, hostControlPinBOe;
   logic        hostDataStb, mA, mB, hostByteStb, hostByteHalf;
   logic        hostModeActive, gpioModeActive, addrLoadPulse, hostWordValid;
   logic [9:0]  gpioInVal;
   logic [15:0] hostAddressRegister, hostWord;
   logic [1:0]  hostWordSel;
   logic        hit;
   logic [15:0] nStb, nHalf;
   logic [9:0]  allOe, allOut;
   int          n_fail = 0;
   int          compares = 0;
   // Pin level: device drive wins where enabled, else the host
   assign hostDataPinsIn = (hostDataPinsOe & hostDataPinsOut)
                         | (~hostDataPinsOe & mData);
   assign hostControlPinAIn = hostControlPinAOe ? hostControlPinAOut : mA;
   assign hostControlPinBIn = hostControlPinBOe ? hostControlPinBOut : mB;
   assign allOe  = {hostControlPinBOe, hostControlPinAOe, hostDataPinsOe};
   assign allOut = {hostControlPinBOut, hostControlPinAOut, hostDataPinsOut};
   hps_pin_mux u_dut (.*);
   hps_host_model u_host (.*);
   always #5 ref_clk = ~ref_clk;
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic doRst(input logic s);
      @(posedge ref_clk);
      portFunctionStrap <= s;
      rst_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      tick(2);
   endtask
   task automatic run(input logic a, input logic [15:0] w);
      hit = 1'b0;
      nStb = 16'h0000;
      nHalf = 16'h0000;
      @(posedge ref_clk);
      word <= w;
      startAddr <= a;
      startData <= !a;
      @(posedge ref_clk);
      startAddr <= 1'b0;
      startData <= 1'b0;
      repeat (12) begin
         @(negedge ref_clk);
         if ((a ? addrLoadPulse : hostWordValid) === 1'b1) hit = 1'b1;
         if (hostByteStb === 1'b1) nStb = nStb + 16'h0001;
         if (hostByteStb === 1'b1 && hostByteHalf === 1'b1)
            nHalf = nHalf + 16'h0001;
      end
   endtask
   task automatic scnHost();
      doRst(1'b1);
      check({hostModeActive, gpioModeActive}, 2'b10);
      check(allOe, 16'h0000);
   endtask
   task automatic scnAddr();
      run(1'b1, 16'hA55A);
      check(hit, 1'b1);
      check(hostAddressRegister, 16'hA55A);
      run(1'b1, 16'h0FF0);
      check(hostAddressRegister, 16'h0FF0);
   endtask
   task automatic scnSel();
      for (int s = 0; s < 4; s++) begin
         @(posedge ref_clk);
         {registerSelectLine1, registerSelectLine0} <= s[1:0];
         run(1'b0, 16'hC3A0 | 16'(s));
         check(hit, 1'b1);
         check(hostWord, 16'hC3A0 | 16'(s));
         check(hostWordSel, s[1:0]);
         check(nStb, 16'h0002);
         check(nHalf, 16'h0001);
         check({8'h00, hostByte}, 16'h003C);
         if (s == 2) check(hostAddressRegister, 16'hC3A2);
      end
   endtask
   task automatic scnEnable();
      @(posedge ref_clk);
      hostReadByte <= 8'h96;
      hostReadDrive <= 1'b1;
      portEnableInput <= 1'b0;
      tick(2);
      check(hostDataPinsOe, 8'h00);
      @(posedge ref_clk);
      portEnableInput <= 1'b1;
      tick(2);
      check({hostDataPinsOe, hostDataPinsOut}, 16'hFF96);
      @(posedge ref_clk);
      hostReadDrive <= 1'b0;
   endtask
   task automatic scnStrap();
      @(posedge ref_clk);
      portFunctionStrap <= 1'b0;
      tick(3);
      check({hostModeActive, gpioModeActive}, 2'b10);
   endtask
   task automatic scnGpio();
      doRst(1'b0);
      check({hostModeActive, gpioModeActive}, 2'b01);
      check(allOe, 16'h0000);
      run(1'b1, 16'h3C5A);
      check(hit, 1'b0);
      run(1'b0, 16'h3C5A);
      check(hit, 1'b0);
      check(nStb, 16'h0000);
      check(gpioInVal, 10'h0C3);
      @(posedge ref_clk);
      gpioDirOut <= 10'h3FF;
      gpioOutVal <= 10'h2A5;
      tick(2);
      check(allOe, 16'h03FF);
      check(allOut, 16'h02A5);
      @(posedge ref_clk);
      gpioDirOut <= 10'h000;
   endtask
   task automatic conclude();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      scnHost();
      scnAddr();
      scnSel();
      scnEnable();
      scnStrap();
      scnGpio();
      conclude();
   end
   // Whole sequence needs about 150 cycles
   initial begin
      #20000;
      n_fail++;
      conclude();
   end
endmodule // host_port_pin_function_strap_test
